//--- hdl/adcc_pkg.sv
// Shared constants and types for the converter control block.
// Assumes a 40 MHz core clock and a 32-bit APB register bus.
`default_nettype none

package adcc_pkg;
	localparam int CLK_NS = 25;
	localparam int TAD_NS = 200;
	localparam int TAD_CYC = (TAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_TADS = 11;
	localparam int HOLD_TADS = 2;
	localparam int RES_W = 10;
	localparam logic [3:0] TAD_LAST = 4'(TAD_CYC - 1);
	localparam logic [3:0] CONV_LAST = 4'(CONV_TADS - 1);
	localparam logic [3:0] HOLD_LAST = 4'(HOLD_TADS - 1);

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] RESH_OFS = 8'h04;
	localparam logic [7:0] RESL_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	localparam logic [7:0] CLR_OFS = 8'h10;
	localparam logic [7:0] IEN_OFS = 8'h14;

	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_RESH = 3'h1;
	localparam logic [2:0] IDX_RESL = 3'h2;
	localparam logic [2:0] IDX_STAT = 3'h3;
	localparam logic [2:0] IDX_CLR = 3'h4;
	localparam logic [2:0] IDX_IEN = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	localparam int JUSTIFY_BIT = 7;
	localparam int REF_BIT = 6;
	localparam int CHAN_LSB = 2;
	localparam int GO_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hCD;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] RES_RST = 10'h000;

	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam logic [1:0] IRQ_RST = 2'h0;

	typedef enum logic [1:0] {SAR_IDLE, SAR_CONV, SAR_HOLD} adcc_sar_state_type;
endpackage

`default_nettype wire

//--- hdl/adcc_sar.sv
// Successive-approximation sequencer: one settle period, then one bit per period.
// Assumes start and abort are single-cycle pulses and comp is already synchronised.
`default_nettype none

module adcc_sar (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic comp,
	output logic idle,
	output logic done_q,
	output logic [9:0] code_q,
	output logic [9:0] result_q
);
	adcc_pkg::adcc_sar_state_type state_q, state_d;
	logic [3:0] tcnt_q, tcnt_d;
	logic [3:0] idx_q, idx_d;
	logic [3:0] bitpos;
	logic [9:0] code_d;
	logic [9:0] result_d;
	logic done_d;
	logic tad_end;

	assign idle = (state_q == adcc_pkg::SAR_IDLE);

	always_comb
	begin
		state_d = state_q;
		tcnt_d = tcnt_q;
		idx_d = idx_q;
		code_d = code_q;
		result_d = result_q;
		done_d = 1'b0;
		tad_end = (tcnt_q == adcc_pkg::TAD_LAST);
		bitpos = 4'(adcc_pkg::RES_W) - idx_q;
		case (state_q)
		adcc_pkg::SAR_IDLE:
		begin
			if (start)
			begin
				state_d = adcc_pkg::SAR_CONV;
				tcnt_d = 4'h0;
				idx_d = 4'h0;
				code_d = 10'h000;
			end
		end
		adcc_pkg::SAR_CONV:
		begin
			tcnt_d = tad_end ? 4'h0 : tcnt_q + 4'h1;
			if (abort)
			begin
				// Partial code is dropped; the caller keeps the old result.
				state_d = adcc_pkg::SAR_HOLD;
				tcnt_d = 4'h0;
				idx_d = 4'h0;
				code_d = 10'h000;
			end
			else if (tad_end)
			begin
				idx_d = idx_q + 4'h1;
				if (idx_q == 4'h0)
					code_d[adcc_pkg::RES_W - 1] = 1'b1;
				else
				begin
					code_d[bitpos] = comp;
					if (bitpos != 4'h0)
						code_d[bitpos - 4'h1] = 1'b1;
				end
				if (idx_q == adcc_pkg::CONV_LAST)
				begin
					state_d = adcc_pkg::SAR_IDLE;
					done_d = 1'b1;
					result_d = code_d;
				end
			end
		end
		adcc_pkg::SAR_HOLD:
		begin
			tcnt_d = tad_end ? 4'h0 : tcnt_q + 4'h1;
			if (tad_end)
			begin
				idx_d = idx_q + 4'h1;
				if (idx_q == adcc_pkg::HOLD_LAST)
					state_d = adcc_pkg::SAR_IDLE;
			end
		end
		default:
			state_d = adcc_pkg::SAR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_q <= adcc_pkg::SAR_IDLE;
			tcnt_q <= 4'h0;
			idx_q <= 4'h0;
			code_q <= adcc_pkg::RES_RST;
			result_q <= adcc_pkg::RES_RST;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			tcnt_q <= tcnt_d;
			idx_q <= idx_d;
			code_q <= code_d;
			result_q <= result_d;
			done_q <= done_d;
		end
	end
endmodule // adcc_sar

`default_nettype wire

//--- hdl/adcc_top.sv
// Converter control: APB registers, start/abort control, result and interrupt logic.
// Assumes an external comparator and DAC/mux on the analog side; comp_in is asynchronous.
`default_nettype none

module adcc_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic comp_in,
	output logic reference_select_q,
	output logic [1:0] channel_select_q,
	output logic [3:0] channel_route_q,
	output logic converter_power_q,
	output logic sample_switch_q,
	output logic [9:0] dac_code_q,
	output logic irq_q
);
	logic [7:0] ctrl_q, ctrl_d;
	logic go_q, go_d;
	logic [9:0] res_q, res_d;
	logic [1:0] stat_q, stat_d;
	logic [1:0] ien_q, ien_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic irq_d, sample_d;
	logic [3:0] route_d;
	logic comp_m_q, comp_s_q;
	logic [2:0] sel_idx;
	logic acc, wr, ctrl_wr;
	logic start, abort, abort_go;
	logic sar_idle, sar_done;
	logic [9:0] sar_result;
	logic [7:0] ctrl_rd;
	logic [1:0] ev_set;

	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		case (a)
		adcc_pkg::CTRL_OFS: reg_sel = adcc_pkg::IDX_CTRL;
		adcc_pkg::RESH_OFS: reg_sel = adcc_pkg::IDX_RESH;
		adcc_pkg::RESL_OFS: reg_sel = adcc_pkg::IDX_RESL;
		adcc_pkg::STAT_OFS: reg_sel = adcc_pkg::IDX_STAT;
		adcc_pkg::CLR_OFS: reg_sel = adcc_pkg::IDX_CLR;
		adcc_pkg::IEN_OFS: reg_sel = adcc_pkg::IDX_IEN;
		default: reg_sel = adcc_pkg::IDX_NONE;
		endcase
	endfunction

	adcc_sar u_sar (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start),
		.abort(abort),
		.comp(comp_s_q),
		.idle(sar_idle),
		.done_q(sar_done),
		.code_q(dac_code_q),
		.result_q(sar_result)
	);

	// The comparator output is asynchronous to the core clock.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			comp_m_q <= 1'b0;
			comp_s_q <= 1'b0;
		end
		else
		begin
			comp_m_q <= comp_in;
			comp_s_q <= comp_m_q;
		end
	end

	always_comb
	begin
		sel_idx = reg_sel(paddr);
		acc = psel & penable & pready_q;
		wr = acc & pwrite;
		ctrl_wr = wr & (sel_idx == adcc_pkg::IDX_CTRL);
		// No acquisition timer here: software owns the settling wait.
		start = ctrl_wr & pwdata[adcc_pkg::GO_BIT] & pwdata[adcc_pkg::EN_BIT]
			& ctrl_q[adcc_pkg::EN_BIT] & ~go_q & sar_idle;
		abort = ctrl_wr & go_q & ~sar_done
			& ~(pwdata[adcc_pkg::GO_BIT] & pwdata[adcc_pkg::EN_BIT]);
		abort_go = abort & pwdata[adcc_pkg::EN_BIT];
		ctrl_rd = ctrl_q | ({7'h00, go_q} << adcc_pkg::GO_BIT);
	end

	always_comb
	begin
		ctrl_d = ctrl_q;
		go_d = go_q;
		if (ctrl_wr)
		begin
			ctrl_d = pwdata[7:0] & adcc_pkg::CTRL_WMASK;
			go_d = go_q ? ~abort : start;
		end
		if (sar_done)
			go_d = 1'b0;
	end

	always_comb
	begin
		res_d = res_q;
		if (sar_done)
			res_d = sar_result;
		ev_set = 2'h0;
		ev_set[adcc_pkg::IRQ_DONE_BIT] = sar_done;
		ev_set[adcc_pkg::IRQ_ABORT_BIT] = abort;
		stat_d = stat_q;
		if (wr && sel_idx == adcc_pkg::IDX_CLR)
			stat_d = stat_q & ~pwdata[1:0];
		// A new event in the clearing cycle survives the clear.
		stat_d = stat_d | ev_set;
		ien_d = ien_q;
		if (wr && sel_idx == adcc_pkg::IDX_IEN)
			ien_d = pwdata[1:0];
		irq_d = |(stat_d & ien_d);
	end

	always_comb
	begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = pready_d & (sel_idx == adcc_pkg::IDX_NONE);
		prdata_d = 32'h0000_0000;
		if (pready_d && !pwrite)
		begin
			case (sel_idx)
			adcc_pkg::IDX_CTRL: prdata_d = 32'(ctrl_rd);
			adcc_pkg::IDX_RESH:
				prdata_d = ctrl_q[adcc_pkg::JUSTIFY_BIT] ? 32'(res_q[9:8])
					: 32'(res_q[9:2]);
			adcc_pkg::IDX_RESL:
				prdata_d = ctrl_q[adcc_pkg::JUSTIFY_BIT] ? 32'(res_q[7:0])
					: 32'({res_q[1:0], 6'h00});
			adcc_pkg::IDX_STAT: prdata_d = 32'(stat_q);
			adcc_pkg::IDX_IEN: prdata_d = 32'(ien_q);
			default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// The switch closes only while powered and idle, which also restarts acquisition.
	always_comb
	begin
		sample_d = ctrl_q[adcc_pkg::EN_BIT] & sar_idle & ~go_q & ~start;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_route
			always_comb
			begin
				route_d[gi] = ctrl_d[adcc_pkg::EN_BIT]
					& (ctrl_d[adcc_pkg::CHAN_LSB +: 2] == 2'(gi));
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= adcc_pkg::CTRL_RST;
			go_q <= 1'b0;
			res_q <= adcc_pkg::RES_RST;
			stat_q <= adcc_pkg::IRQ_RST;
			ien_q <= adcc_pkg::IRQ_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
			sample_switch_q <= 1'b0;
			channel_route_q <= 4'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			go_q <= go_d;
			res_q <= res_d;
			stat_q <= stat_d;
			ien_q <= ien_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
			sample_switch_q <= sample_d;
			channel_route_q <= route_d;
		end
	end

	assign reference_select_q = ctrl_q[adcc_pkg::REF_BIT];
	assign channel_select_q = ctrl_q[adcc_pkg::CHAN_LSB +: 2];
	assign converter_power_q = ctrl_q[adcc_pkg::EN_BIT];

	localparam int CONV_DLY = adcc_pkg::TAD_CYC * adcc_pkg::CONV_TADS + 1;
	localparam int REACQ_GAP = adcc_pkg::TAD_CYC * adcc_pkg::HOLD_TADS - 6;
	localparam logic [7:0] BUSY_LEN = 8'(adcc_pkg::TAD_CYC * adcc_pkg::CONV_TADS);

	// Assertion helper: cycles that busy has read 1; it rests at zero while idle.
	logic [7:0] busy_len_q, busy_len_d;

	always_comb
	begin
		busy_len_d = go_q ? busy_len_q + 8'h01 : 8'h00;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			busy_len_q <= 8'h00;
		else
			busy_len_q <= busy_len_d;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	done_clears_go_a: assert property (sar_done |=> !go_q)
		else $error("busy flag not cleared after completion");
	// An aborted conversion never completes, so the timing is checked from the done side.
	conv_time_a: assert property (sar_done |-> $past(start, CONV_DLY))
		else $error("conversion did not finish in eleven periods");
	busy_read_a: assert property (start |=> go_q [*8])
		else $error("busy flag dropped during conversion");
	busy_len_a: assert property (sar_done |-> busy_len_q == BUSY_LEN)
		else $error("busy did not read 1 for the whole conversion");
	busy_max_a: assert property (go_q |-> busy_len_q <= BUSY_LEN)
		else $error("busy flag stayed set past the conversion length");
	dis_start_a: assert property (ctrl_wr && !ctrl_q[adcc_pkg::EN_BIT] |=> !go_q)
		else $error("start accepted while disabled");
	en_off_a: assert property (!ctrl_q[adcc_pkg::EN_BIT] |=> !sample_switch_q && !sar_done)
		else $error("converter active while disabled");
	route_off_a: assert property (!ctrl_q[adcc_pkg::EN_BIT] |-> channel_route_q == 4'h0)
		else $error("input switch closed while disabled");
	route_sel_a: assert property (ctrl_q[adcc_pkg::EN_BIT]
		|-> channel_route_q == 4'h1 << ctrl_q[adcc_pkg::CHAN_LSB +: 2])
		else $error("input switch does not match the selected channel");
	keep_res_a: assert property (abort |=> $stable(res_q) [*8])
		else $error("result changed after abort");
	hold_refuse_a: assert property (abort |=> !go_q [*8])
		else $error("start accepted during the abort holdoff");
	reacq_a: assert property (abort_go |-> ##1 (!sample_switch_q) [*8] ##REACQ_GAP
		(sample_switch_q || !ctrl_q[adcc_pkg::EN_BIT] || go_q))
		else $error("acquisition not restarted two periods after abort");
	sample_busy_a: assert property (go_q |=> !sample_switch_q)
		else $error("sample switch closed during a conversion");
	irq_flag_a: assert property (sar_done |=> stat_q[adcc_pkg::IRQ_DONE_BIT]
		&& res_q == $past(sar_result))
		else $error("completion did not set flag and load result");
	done_pulse_a: assert property (sar_done |=> !sar_done)
		else $error("completion pulse longer than one cycle");
	sticky_done_a: assert property (stat_q[adcc_pkg::IRQ_DONE_BIT]
		&& !(wr && sel_idx == adcc_pkg::IDX_CLR && pwdata[adcc_pkg::IRQ_DONE_BIT])
		|=> stat_q[adcc_pkg::IRQ_DONE_BIT])
		else $error("done flag dropped without a clear");
	irq_level_a: assert property (irq_q == |(stat_q & ien_q))
		else $error("interrupt line does not follow enabled status");

	// The bus answers for exactly one cycle and never shows reserved control bits.
	pready_pulse_a: assert property (pready_q |=> !pready_q)
		else $error("bus answer held longer than one cycle");
	err_ready_a: assert property (pslverr_q |-> pready_q)
		else $error("error response without ready");
	ctrl_view_a: assert property (pready_q && !pwrite
		&& sel_idx == adcc_pkg::IDX_CTRL |-> prdata_q[5:4] == 2'h0
		&& prdata_q[adcc_pkg::GO_BIT] == $past(go_q))
		else $error("control read shows reserved bits or stale busy");
	unmapped_a: assert property (wr && sel_idx == adcc_pkg::IDX_NONE
		|=> $stable(ctrl_q) && $stable(ien_q))
		else $error("write to an unmapped address changed a register");

	conv_done_c: cover property (start ##CONV_DLY sar_done);
	abort_c: cover property (abort_go ##[1:20] sample_switch_q);
	irq_c: cover property (sar_done ##1 irq_q);
	power_off_c: cover property (abort && !pwdata[adcc_pkg::EN_BIT]);
	ref_conv_c: cover property (start && ctrl_q[adcc_pkg::REF_BIT]);
endmodule // adcc_top

`default_nettype wire

//--- tb/adcc_analog_model.sv
// Comparator model of the four analog inputs and the positive reference.
// Assumes channel_route_q is one-hot and dac_code_q holds the trial code.
`default_nettype none

module adcc_analog_model (
	input wire logic reference_select_q,
	input wire logic [3:0] channel_route_q,
	input wire logic converter_power_q,
	input wire logic [9:0] dac_code_q,
	input wire logic [9:0] level [4],
	output logic comp_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [10:0] v;
	always_comb
	begin
		v = 11'h000;
		for (int i = 0; i < 4; i++)
			if (channel_route_q[i]) v = {1'b0, level[i]};
		// The pin reference is half the supply, so codes double and clip.
		if (reference_select_q) v = (v << 1) > 11'h3FF ? 11'h3FF : v << 1;
		// Inputs sit half a step above their level, so an equal code counts as above.
		comp_in = converter_power_q && v >= {1'b0, dac_code_q};
	end
endmodule // adcc_analog_model

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the converter control block over APB.
// Assumes the comparator model stands in for the analog side.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_q, r;
	logic pready_q, pslverr_q, comp_in, reference_select_q, converter_power_q;
	logic sample_switch_q, irq_q, err;
	logic [1:0] channel_select_q;
	logic [3:0] channel_route_q;
	logic [9:0] dac_code_q, e, prev;
	logic [9:0] level [4] = '{10'h000, 10'h3FF, 10'h155, 10'h200};
	logic [7:0] c;
	int failures = 0, samples_checked = 0, n;
	adcc_top adcc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .comp_in(comp_in),
		.reference_select_q(reference_select_q), .channel_select_q(channel_select_q),
		.channel_route_q(channel_route_q), .converter_power_q(converter_power_q),
		.sample_switch_q(sample_switch_q), .dac_code_q(dac_code_q), .irq_q(irq_q));
	adcc_analog_model adcc_analog_model_inst (.reference_select_q(reference_select_q),
		.channel_route_q(channel_route_q), .converter_power_q(converter_power_q),
		.dac_code_q(dac_code_q), .level(level), .comp_in(comp_in));
	initial
	begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// The pin reference is modelled as half the supply, so the code doubles and clips.
	function automatic logic [9:0] exp_code(input logic [9:0] lv, input logic rf);
		if (!rf)
			exp_code = lv;
		else if (lv > 10'h1FF)
			exp_code = 10'h3FF;
		else
			exp_code = {lv[8:0], 1'b0};
	endfunction
	function automatic logic [31:0] exp_word(input logic [9:0] v, input logic j, input logic hi);
		if (hi)
			exp_word = j ? 32'(v[9:8]) : 32'(v[9:2]);
		else
			exp_word = j ? 32'(v[7:0]) : 32'({v[1:0], 6'h00});
	endfunction
	task automatic close_out();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Called just after a rising edge; holds the request until pready_q is sampled.
	// One idle edge follows, so a second call never re-drives psel in the same step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready_q !== 1'b1)
			@(posedge core_clk);
		r = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic conv(input logic [1:0] ch, input logic rf, input logic j, input logic ie);
		c = {j, rf, 2'b00, ch, 2'b01};
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h14, {31'h0, ie});
		apb(1'b1, 8'h00, 32'(c & 8'hFE));
		apb(1'b1, 8'h00, 32'(c));
		repeat (40) @(posedge core_clk);
		check(32'(channel_route_q), 32'(4'b0001 << ch));
		check(32'(channel_select_q), 32'(ch));
		check(32'(reference_select_q), 32'(rf));
		check(32'(sample_switch_q), 32'h1);
		apb(1'b1, 8'h00, 32'(c | 8'h02));
		n = 0;
		// Counted from one edge after the accepting edge, irq_q rises after eleven periods.
		while (ie && irq_q !== 1'b1 && n < 200)
		begin
			@(posedge core_clk) #1;
			n++;
		end
		if (ie) check(32'(n), 32'(adcc_pkg::CONV_TADS * adcc_pkg::TAD_CYC));
		r = 32'h2;
		while (r[1] === 1'b1)
			apb(1'b0, 8'h00, 32'h0);
		check(r, 32'(c));
		e = exp_code(level[ch], rf);
		check(32'(dac_code_q), 32'(e));
		apb(1'b0, 8'h04, 32'h0);
		check(r, exp_word(e, j, 1'b1));
		apb(1'b0, 8'h08, 32'h0);
		check(r, exp_word(e, j, 1'b0));
		apb(1'b0, 8'h0C, 32'h0);
		check(r, 32'h1);
		check(32'(irq_q), 32'(ie));
		apb(1'b1, 8'h10, 32'h3);
		@(posedge core_clk);
		check(32'(irq_q), 32'h0);
	endtask
	initial
	begin
		#(25 * 30000);
		failures++;
		close_out();
	end
	initial
	begin
		void'($urandom(32'had798628));
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		check(r, 32'h0);
		apb(1'b1, 8'h00, 32'hFF);
		apb(1'b0, 8'h00, 32'h0);
		check(r, 32'hCD);
		repeat (100) @(posedge core_clk);
		apb(1'b0, 8'h0C, 32'h0);
		check(r, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check({r[31:1], err}, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			if (k > 3) level[k % 4] = 10'($urandom);
			conv(2'(k), k > 3 ? 1'($urandom) : 1'b0, 1'(k / 2), k > 1 ? 1'($urandom) : 1'b1);
		end
		prev = e;
		apb(1'b1, 8'h00, 32'h05);
		repeat (40) @(posedge core_clk);
		apb(1'b1, 8'h00, 32'h07);
		repeat (20) @(posedge core_clk);
		apb(1'b1, 8'h00, 32'h05);
		apb(1'b0, 8'h0C, 32'h0);
		check(r, 32'h2);
		apb(1'b0, 8'h08, 32'h0);
		check(r, exp_word(prev, 1'b0, 1'b0));
		repeat (20) @(posedge core_clk);
		check(32'({sample_switch_q, channel_route_q}), 32'h12);
		apb(1'b1, 8'h00, 32'h07);
		repeat (20) @(posedge core_clk);
		apb(1'b1, 8'h00, 32'h00);
		@(posedge core_clk);
		check(32'({converter_power_q, channel_route_q}), 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check(r, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		check(r, exp_word(prev, 1'b0, 1'b0));
		close_out();
	end
endmodule // tb_top

`default_nettype wire
